// ==== dmc_top.sv ====
// Channel mode, frame-end counter and interrupt enable block, AXI4-Lite
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
module dmc_top (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire dmc_pkg::dmc_addr_t awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   // AXI4-Lite write data
   input  wire dmc_pkg::dmc_word_t wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read address
   input  wire dmc_pkg::dmc_addr_t araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   // AXI4-Lite read data
   output dmc_pkg::dmc_word_t     rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // CPU interface mode strap pins
   input  wire logic [1:0]        cpu_mode_pin,
   // Events from the transfer engine
   input  wire logic              transfer_done_evt,
   input  wire logic              frame_done_evt,
   input  wire logic              buffer_error_evt,
   // Configuration towards the transfer engine
   output logic                   transfer_mode_select,
   output logic                   multi_frame_select,
   output logic                   frame_counter_enable,
   output dmc_pkg::dmc_nib_t      frame_end_event_count,
   // Interrupt
   output logic                   irq
);
   import dmc_pkg::*;

   // ======================================================================
   // Address decode: one word per index, upper address bits must be zero
   function automatic logic reg_hit(input dmc_addr_t addr,
                                    input dmc_byte_t idx_lo,
                                    input dmc_byte_t idx_hi,
                                    input logic      hi_mode);
      logic [7:0] want;
      want    = hi_mode ? idx_hi : idx_lo;
      reg_hit = (addr[11:10] == 2'h0) && (addr[9:2] == want);
   endfunction

   // ======================================================================
   // State
   logic [1:0] strap_meta_reg;
   logic [1:0] strap_meta_next;
   logic [1:0] strap_sync_reg;
   logic [1:0] strap_sync_next;
   dmc_byte_t  mode_reg;
   dmc_byte_t  mode_next;
   dmc_byte_t  ien_reg;
   dmc_byte_t  ien_next;
   dmc_wr_e    wr_state_reg;
   dmc_wr_e    wr_state_next;
   dmc_rd_e    rd_state_reg;
   dmc_rd_e    rd_state_next;
   logic       aw_full_reg;
   logic       aw_full_next;
   logic       w_full_reg;
   logic       w_full_next;
   dmc_addr_t  aw_addr_reg;
   dmc_addr_t  aw_addr_next;
   dmc_byte_t  w_data_reg;
   dmc_byte_t  w_data_next;
   logic       w_strb_reg;
   logic       w_strb_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;
   dmc_word_t  rdata_reg;
   dmc_word_t  rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;

   // Decode and strobes
   logic       hi_mode;
   logic       wr_fire;
   logic       ar_fire;
   logic       w_mode_hit;
   logic       w_ien_hit;
   logic       w_cnt_hit;
   logic       w_stat_hit;
   logic       w_mask_hit;
   logic       w_mapped;
   logic       r_mode_hit;
   logic       r_cnt_hit;
   logic       r_ien_hit;
   logic       r_stat_hit;
   logic       r_mask_hit;
   logic       r_mapped;
   logic       chained;
   dmc_nib_t   gated_evt;
   dmc_nib_t   irq_status;
   dmc_nib_t   irq_mask;
   logic       count_ovf;
   dmc_nib_t   count_val;

   // Strap pins cross into the clock domain through two flip-flops
   always_comb begin
      strap_meta_next = cpu_mode_pin;
      strap_sync_next = strap_meta_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_meta_reg <= 2'h0;
         strap_sync_reg <= 2'h0;
      end else begin
         strap_meta_reg <= strap_meta_next;
         strap_sync_reg <= strap_sync_next;
      end
   end

   // Modes 2 and 3 swap the byte lanes, so the decode follows bit 1
   assign hi_mode = strap_sync_reg[1];

   // ======================================================================
   // Register decode for the held write and the offered read
   assign w_mode_hit = reg_hit(aw_addr_reg, `DMC_IDX_MODE_LO,
                               `DMC_IDX_MODE_HI, hi_mode);      // see [RL1]
   assign w_cnt_hit  = reg_hit(aw_addr_reg, `DMC_IDX_CNT_LO,
                               `DMC_IDX_CNT_HI, hi_mode);       // see [RL5]
   assign w_ien_hit  = reg_hit(aw_addr_reg, `DMC_IDX_IEN_LO,
                               `DMC_IDX_IEN_HI, hi_mode);       // see [RL6]
   assign w_stat_hit = reg_hit(aw_addr_reg, `DMC_IDX_STAT,
                               `DMC_IDX_STAT, hi_mode);
   assign w_mask_hit = reg_hit(aw_addr_reg, `DMC_IDX_MASK,
                               `DMC_IDX_MASK, hi_mode);
   assign w_mapped   = w_mode_hit | w_cnt_hit | w_ien_hit |
                       w_stat_hit | w_mask_hit;
   assign r_mode_hit = reg_hit(araddr, `DMC_IDX_MODE_LO,
                               `DMC_IDX_MODE_HI, hi_mode);      // see [RL1]
   assign r_cnt_hit  = reg_hit(araddr, `DMC_IDX_CNT_LO,
                               `DMC_IDX_CNT_HI, hi_mode);       // see [RL5]
   assign r_ien_hit  = reg_hit(araddr, `DMC_IDX_IEN_LO,
                               `DMC_IDX_IEN_HI, hi_mode);       // see [RL6]
   assign r_stat_hit = reg_hit(araddr, `DMC_IDX_STAT,
                               `DMC_IDX_STAT, hi_mode);
   assign r_mask_hit = reg_hit(araddr, `DMC_IDX_MASK,
                               `DMC_IDX_MASK, hi_mode);
   assign r_mapped   = r_mode_hit | r_cnt_hit | r_ien_hit |
                       r_stat_hit | r_mask_hit;

   // ======================================================================
   // Write channel: address and data are collected in either order
   assign awready = (wr_state_reg == DMC_WR_COLLECT) && !aw_full_reg;
   assign wready  = (wr_state_reg == DMC_WR_COLLECT) && !w_full_reg;
   assign wr_fire = (wr_state_reg == DMC_WR_COLLECT) && aw_full_reg &&
                    w_full_reg;
   assign bvalid  = (wr_state_reg == DMC_WR_RESP);
   assign bresp   = bresp_reg;

   always_comb begin
      wr_state_next = wr_state_reg;
      aw_full_next  = aw_full_reg;
      w_full_next   = w_full_reg;
      aw_addr_next  = aw_addr_reg;
      w_data_next   = w_data_reg;
      w_strb_next   = w_strb_reg;
      bresp_next    = bresp_reg;
      case (wr_state_reg)
         DMC_WR_COLLECT: begin
            if (awvalid && awready) begin
               aw_full_next = 1'b1;
               aw_addr_next = awaddr;
            end
            if (wvalid && wready) begin
               w_full_next = 1'b1;
               w_data_next = wdata[7:0];
               w_strb_next = wstrb[0];
            end
            if (wr_fire) begin
               aw_full_next  = 1'b0;
               w_full_next   = 1'b0;
               bresp_next    = w_mapped ? `DMC_RESP_OKAY : `DMC_RESP_SLVERR;
               wr_state_next = DMC_WR_RESP;
            end
         end
         DMC_WR_RESP: begin
            if (bready) begin
               wr_state_next = DMC_WR_COLLECT;
            end
         end
         default: begin
            wr_state_next = DMC_WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= DMC_WR_COLLECT;
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_addr_reg  <= 12'h000;
         w_data_reg   <= 8'h00;
         w_strb_reg   <= 1'b0;
         bresp_reg    <= `DMC_RESP_OKAY;
      end else begin
         wr_state_reg <= wr_state_next;
         aw_full_reg  <= aw_full_next;
         w_full_reg   <= w_full_next;
         aw_addr_reg  <= aw_addr_next;
         w_data_reg   <= w_data_next;
         w_strb_reg   <= w_strb_next;
         bresp_reg    <= bresp_next;
      end
   end

   // ======================================================================
   // Control registers; unused bits are never stored so they read zero
   always_comb begin
      mode_next = mode_reg;
      ien_next  = ien_reg;
      if (wr_fire && w_strb_reg && w_mode_hit) begin
         mode_next = w_data_reg & `DMC_MODE_WMASK;        // see [RL2]
      end
      if (wr_fire && w_strb_reg && w_ien_hit) begin
         ien_next = w_data_reg & `DMC_IEN_WMASK;          // see [RL6]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= `DMC_MODE_RESET;
         ien_reg  <= `DMC_IEN_RESET;
      end else begin
         mode_reg <= mode_next;
         ien_reg  <= ien_next;
      end
   end

   assign transfer_mode_select  = mode_reg[`DMC_BIT_XFER_MODE]; // see [RL2]
   assign multi_frame_select    = mode_reg[`DMC_BIT_MULTI_FRM]; // see [RL3]
   assign frame_counter_enable  = mode_reg[`DMC_BIT_CNT_EN];    // see [RL4]
   assign frame_end_event_count = count_val;
   assign chained               = transfer_mode_select;

   // ======================================================================
   // Read channel; data is registered, the counter is read-only
   assign arready = (rd_state_reg == DMC_RD_IDLE);
   assign ar_fire = arvalid && arready;
   assign rvalid  = (rd_state_reg == DMC_RD_DATA);
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   always_comb begin
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      case (rd_state_reg)
         DMC_RD_IDLE: begin
            if (ar_fire) begin
               rdata_next = 32'h0000_0000;
               if (r_mode_hit) begin
                  rdata_next[7:0] = mode_reg;
               end
               if (r_cnt_hit) begin
                  rdata_next[3:0] = count_val;           // see [RL5]
               end
               if (r_ien_hit) begin
                  rdata_next[7:0] = ien_reg;             // see [RL6]
               end
               if (r_stat_hit) begin
                  rdata_next[7:4] = irq_status;
               end
               if (r_mask_hit) begin
                  rdata_next[7:4] = irq_mask;
               end
               rresp_next    = r_mapped ? `DMC_RESP_OKAY : `DMC_RESP_SLVERR;
               rd_state_next = DMC_RD_DATA;
            end
         end
         DMC_RD_DATA: begin
            if (rready) begin
               rd_state_next = DMC_RD_IDLE;
            end
         end
         default: begin
            rd_state_next = DMC_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= DMC_RD_IDLE;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= `DMC_RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   // ======================================================================
   // Counter; relies on software clearing the enable in single-block mode
   dmc_frame_counter u_counter (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .count_en  (frame_counter_enable),  // see [RL10]
      .frame_evt (frame_done_evt),
      .count_ovf (count_ovf),
      .count     (count_val)
   );

   // Events pass only while enabled; three of them only in chained mode
   assign gated_evt[3] = transfer_done_evt & ien_reg[7];   // see [RL7]
   assign gated_evt[2] = frame_done_evt & ien_reg[6] & chained; // see [RL9]
   assign gated_evt[1] = buffer_error_evt & ien_reg[5] & chained; // see [RL9]
   assign gated_evt[0] = count_ovf & chained &             // see [RL8]
                         ien_reg[`DMC_BIT_OVF_IE];

   dmc_irq_status u_irq (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .events   (gated_evt),
      .clear_we (wr_fire && w_strb_reg && w_stat_hit),
      .mask_we  (wr_fire && w_strb_reg && w_mask_hit),
      .wr_nib   (w_data_reg[7:4]),
      .status   (irq_status),
      .mask     (irq_mask),
      .irq      (irq)
   );

   // ======================================================================
   // Checks
   mode_write_takes_a: assert property ( // see [RL2]
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && w_strb_reg && w_mode_hit)
      |=> (transfer_mode_select == $past(w_data_reg[4]) &&
           multi_frame_select == $past(w_data_reg[2])))
      else $error("mode write not applied");

   ien_low_zero_a: assert property ( // see [RL6]
      @(posedge aclk) disable iff (!aresetn)
      ien_reg[3:0] == 4'h0)
      else $error("enable low bits not zero");

   cnt_read_value_a: assert property ( // see [RL5]
      @(posedge aclk) disable iff (!aresetn)
      (ar_fire && r_cnt_hit) |=> (rvalid && rdata[31:4] == 28'h0 &&
                                  rdata[3:0] == $past(count_val)))
      else $error("counter read wrong");

   done_needs_enable_a: assert property ( // see [RL7]
      @(posedge aclk) disable iff (!aresetn)
      (transfer_done_evt && !ien_reg[7] && !irq_status[3]) |=> !irq_status[3])
      else $error("done status set while disabled");

   ovf_single_block_a: assert property ( // see [RL8]
      @(posedge aclk) disable iff (!aresetn)
      (count_ovf && !chained && !irq_status[0]) |=> !irq_status[0])
      else $error("overflow status set in single-block mode");

   bresp_unmapped_a: assert property ( // see [RL1]
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && !w_mapped) |=> (bvalid && bresp == 2'h2))
      else $error("unmapped write not refused");

   bvalid_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> (bvalid && $stable(bresp)))
      else $error("write response dropped");
endmodule
`default_nettype wire

// ==== dmc_map.svh ====
// Register indices, field positions, reset values and bus codes
//
// Notes on behaviour
// [RL1] Mode register at index 91H in CPU modes 0/1, at 90H in modes 2/3.
// [RL2] Mode bit 4 selects transfer: 0 single block, 1 chained; resets zero.
// [RL3] Mode bit 2 in chained mode: 0 single frame, 1 multi-frame; resets 0.
// [RL4] Mode bit 1 enables the frame-end event counter; resets to zero.
// [RL5] Counter reads as 4 low bits at 93H or 92H; upper bits read 0.
// [RL6] Interrupt enables at 94H or 95H; low four bits read zero.
// [RL7] Bit 7 enables the end-of-transfer interrupt; resets to zero.
// [RL8] Bit 4 enables counter overflow interrupt, chained mode only; resets 0.
// [RL9] Bits 6 and 5 enable frame-end and buffer error interrupts, chained.
// [RL10] Software keeps the counter enable cleared in single-block mode.
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define DMC_IDX_MODE_LO   8'h91
`define DMC_IDX_MODE_HI   8'h90
`define DMC_IDX_CNT_LO    8'h93
`define DMC_IDX_CNT_HI    8'h92
`define DMC_IDX_IEN_LO    8'h94
`define DMC_IDX_IEN_HI    8'h95
`define DMC_IDX_STAT      8'h9c
`define DMC_IDX_MASK      8'h9d

// ==========================================================================
// Field positions
`define DMC_BIT_XFER_MODE 4
`define DMC_BIT_MULTI_FRM 2
`define DMC_BIT_CNT_EN    1
`define DMC_BIT_DONE_IE   7
`define DMC_BIT_OVF_IE    4
`define DMC_IRQ_LSB       4

// ==========================================================================
// Write masks and reset values
`define DMC_MODE_WMASK    8'h16
`define DMC_IEN_WMASK     8'hf0
`define DMC_MODE_RESET    8'h00
`define DMC_IEN_RESET     8'h00
`define DMC_CNT_RESET     4'h0
`define DMC_CNT_MAX       4'hf
`define DMC_NIB_RESET     4'h0

// ==========================================================================
// AXI response codes
`define DMC_RESP_OKAY     2'h0
`define DMC_RESP_SLVERR   2'h2

`endif

// ==== dmc_pkg.sv ====
// Types shared by the channel mode and interrupt enable block
package dmc_pkg;
   // ======================================================================
   // Bus channel states
   typedef enum logic [0:0] {
      DMC_WR_COLLECT = 1'b0,
      DMC_WR_RESP    = 1'b1
   } dmc_wr_e;

   typedef enum logic [0:0] {
      DMC_RD_IDLE = 1'b0,
      DMC_RD_DATA = 1'b1
   } dmc_rd_e;

   // ======================================================================
   // Data types
   typedef logic [7:0]  dmc_byte_t;
   typedef logic [3:0]  dmc_nib_t;
   typedef logic [11:0] dmc_addr_t;
   typedef logic [31:0] dmc_word_t;
endpackage

// ==== dmc_frame_counter.sv ====
// Frame-end event counter with overflow pulse
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
module dmc_frame_counter (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Control and event
   input  wire logic          count_en,
   input  wire logic          frame_evt,
   // Results
   output logic               count_ovf,
   output dmc_pkg::dmc_nib_t  count
);
   import dmc_pkg::*;

   dmc_nib_t count_reg;
   dmc_nib_t count_next;
   logic     ovf_reg;
   logic     ovf_next;

   // ======================================================================
   // Counting; a disabled counter is held at zero so a fresh run starts clean
   always_comb begin
      count_next = count_reg;
      ovf_next   = 1'b0;
      if (!count_en) begin
         count_next = `DMC_CNT_RESET;              // see [RL4]
      end else if (frame_evt) begin
         count_next = count_reg + 4'h1;            // see [RL4]
         ovf_next   = (count_reg == `DMC_CNT_MAX);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= `DMC_CNT_RESET;
         ovf_reg   <= 1'b0;
      end else begin
         count_reg <= count_next;
         ovf_reg   <= ovf_next;
      end
   end

   assign count     = count_reg;
   assign count_ovf = ovf_reg;

   // ======================================================================
   // Checks
   cnt_disabled_zero_a: assert property ( // see [RL4]
      @(posedge aclk) disable iff (!aresetn)
      !count_en |=> (count == 4'h0))
      else $error("counter not cleared while disabled");

   cnt_wrap_ovf_a: assert property ( // see [RL4]
      @(posedge aclk) disable iff (!aresetn)
      (count_en && frame_evt && count == 4'hf)
      |=> (count_ovf && count == 4'h0))
      else $error("counter wrap did not pulse overflow");
endmodule
`default_nettype wire

// ==== dmc_irq_status.sv ====
// Sticky interrupt status, mask and interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
module dmc_irq_status (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Gated events, same layout as status bits 7..4
   input  wire dmc_pkg::dmc_nib_t events,
   // Software access
   input  wire logic          clear_we,
   input  wire logic          mask_we,
   input  wire dmc_pkg::dmc_nib_t wr_nib,
   // Results
   output dmc_pkg::dmc_nib_t  status,
   output dmc_pkg::dmc_nib_t  mask,
   output logic               irq
);
   import dmc_pkg::*;

   dmc_nib_t status_reg;
   dmc_nib_t status_next;
   dmc_nib_t mask_reg;
   dmc_nib_t mask_next;

   // ======================================================================
   // Write-one-to-clear; a new event in the clearing cycle wins
   always_comb begin
      status_next = status_reg;
      mask_next   = mask_reg;
      if (clear_we) begin
         status_next = status_next & ~wr_nib;
      end
      status_next = status_next | events;
      if (mask_we) begin
         mask_next = wr_nib;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= `DMC_NIB_RESET;
         mask_reg   <= `DMC_NIB_RESET;
      end else begin
         status_reg <= status_next;
         mask_reg   <= mask_next;
      end
   end

   assign status = status_reg;
   assign mask   = mask_reg;
   assign irq    = |(status_reg & mask_reg);

   // ======================================================================
   // Checks
   set_beats_clear_a: assert property ( // see [RL7]
      @(posedge aclk) disable iff (!aresetn)
      (events[3] && clear_we && wr_nib[3]) |=> status[3])
      else $error("event lost against a clear");

   irq_follows_evt_a: assert property ( // see [RL7]
      @(posedge aclk) disable iff (!aresetn)
      (events[3] && mask[3] && !mask_we) |=> irq)
      else $error("unmasked event did not raise irq");
endmodule
`default_nettype wire

// ==== dmc_engine_model.sv ====
// Transfer engine stand-in that issues one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none
module dmc_engine_model (
   // Clock
   input  wire logic       aclk,
   // Requests: bit 0 done, bit 1 frame, bit 2 buffer error
   input  wire logic [2:0] fire,
   // Events
   output logic            transfer_done_evt,
   output logic            frame_done_evt,
   output logic            buffer_error_evt
);
   // ====================================================================
   // Registered so each pulse lands one full cycle on the design side
   always_ff @(posedge aclk) begin
      transfer_done_evt <= fire[0];
      frame_done_evt    <= fire[1];
      buffer_error_evt  <= fire[2];
   end
endmodule
`default_nettype wire

// ==== dmc_channel_bench.sv ====
// Self-checking bench for the channel mode and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
module dmc_channel_bench;
   import dmc_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic irq, tms, mfs, fce;
   logic [2:0] fire = 0;
   logic [1:0] bresp, rresp, cpu_mode_pin = 0;
   dmc_addr_t awaddr = 0, araddr = 0;
   dmc_word_t wdata = 0, rdata, rs = 82;
   dmc_nib_t cnt;
   logic [3:0] wstrb = 0;
   logic te, fe, be;
   logic [33:0] q[$];
   logic [1:0] bq[$];
   int fails = 0, total_checks = 0;
   // ====================================================================
   // Clock, engine model and design
   always #5 aclk = ~aclk;
   dmc_engine_model u_eng (.aclk(aclk), .fire(fire),
      .transfer_done_evt(te), .frame_done_evt(fe), .buffer_error_evt(be));
   dmc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .cpu_mode_pin(cpu_mode_pin),
      .transfer_done_evt(te), .frame_done_evt(fe), .buffer_error_evt(be),
      .transfer_mode_select(tms), .multi_frame_select(mfs),
      .frame_counter_enable(fce), .frame_end_event_count(cnt), .irq(irq));
   // ====================================================================
   // Helpers
   function automatic dmc_word_t xs(input dmc_word_t x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cmp(input string n, input logic [33:0] e,
                      input logic [33:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   // Both channels offered together; ready is sampled at the falling edge,
   // where it already holds the value the next rising edge will see
   task automatic wr(input dmc_byte_t i, input dmc_word_t d,
                     input logic [1:0] e = `DMC_RESP_OKAY);
      logic a, w, b;
      bq.push_back(e);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      a = 1; w = 1; b = 1;
      while (a | w | b) begin
         @(negedge aclk);
         if (a && awready) a = 0;
         if (w && wready) w = 0;
         if (b && bvalid) b = 0;
         @(posedge aclk);
         awvalid <= a;
         wvalid <= w;
         bready <= b;
      end
      // One idle edge so the next call never drives a strobe twice at once
      @(posedge aclk);
   endtask
   // The expected word is noted here and judged by the watcher below
   task automatic rd(input dmc_byte_t i, input logic [33:0] e);
      logic a, r;
      q.push_back(e);
      araddr <= {2'h0, i, 2'h0};
      arvalid <= 1;
      rready <= 1;
      a = 1; r = 1;
      while (a | r) begin
         @(negedge aclk);
         if (a && arready) a = 0;
         if (r && rvalid) r = 0;
         @(posedge aclk);
         arvalid <= a;
         rready <= r;
      end
      @(posedge aclk);
   endtask
   task automatic ev(input logic [2:0] f, input int n);
      repeat (n) begin
         fire <= f;
         @(posedge aclk);
         fire <= 0;
         repeat (2) @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ====================================================================
   // Watcher: each read answer takes the oldest note off the queue
   always @(posedge aclk) begin
      if (bvalid && bready) begin
         cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
      end
      if (rvalid && rready) begin
         if (q.size() == 0) cmp("spare read", 34'h0, {rresp, rdata});
         else cmp("read", q.pop_front(), {rresp, rdata});
      end
   end
   // A hang counts as a mismatch and ends the run the usual way
   initial begin
      #200000;
      fails++;
      complete_run();
   end
   // ====================================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(`DMC_IDX_MODE_LO, 34'h0);
      rd(`DMC_IDX_CNT_LO, 34'h0);
      rd(`DMC_IDX_IEN_LO, 34'h0);
      rd(8'h80, {`DMC_RESP_SLVERR, 32'h0});
      wr(`DMC_IDX_MODE_LO, 32'hffffffff);
      // The high-map index misses in the low map and leaves the mode alone
      wr(`DMC_IDX_MODE_HI, 32'h0, `DMC_RESP_SLVERR);
      rd(`DMC_IDX_MODE_LO, 34'h16);
      cmp("mode", 34'h7, {31'h0, tms, mfs, fce});
      wr(`DMC_IDX_CNT_LO, 32'h5);
      rd(`DMC_IDX_CNT_LO, 34'h0);
      for (int k = 0; k < 3; k++) begin
         rs = xs(rs);
         wr(`DMC_IDX_IEN_LO, rs);
         rd(`DMC_IDX_IEN_LO, {2'h0, 24'h0, rs[7:4], 4'h0});
      end
      $display("test registers done");
      wr(`DMC_IDX_MASK, 32'hf0);
      wr(`DMC_IDX_IEN_LO, 32'h0);
      wr(`DMC_IDX_STAT, 32'hf0);
      ev(3'h1, 1);
      rd(`DMC_IDX_STAT, 34'h0);
      wr(`DMC_IDX_IEN_LO, 32'h90);
      ev(3'h1, 1);
      rd(`DMC_IDX_STAT, 34'h80);
      cmp("irq", 34'h1, {33'h0, irq});
      wr(`DMC_IDX_STAT, 32'h80);
      cmp("irq", 34'h0, {33'h0, irq});
      $display("test done interrupt done");
      // Counter enabled only with chained mode set
      wr(`DMC_IDX_MODE_LO, 32'h12);
      cmp("mode", 34'h5, {31'h0, tms, mfs, fce});
      ev(3'h2, 3);
      rd(`DMC_IDX_CNT_LO, 34'h3);
      cmp("count", 34'h3, {30'h0, cnt});
      ev(3'h2, 14);
      rd(`DMC_IDX_CNT_LO, 34'h1);
      rd(`DMC_IDX_STAT, 34'h10);
      wr(`DMC_IDX_STAT, 32'hf0);
      wr(`DMC_IDX_MODE_LO, 32'h10);
      cmp("mode", 34'h4, {31'h0, tms, mfs, fce});
      rd(`DMC_IDX_CNT_LO, 34'h0);
      wr(`DMC_IDX_IEN_LO, 32'h60);
      ev(3'h6, 1);
      rd(`DMC_IDX_STAT, 34'h60);
      $display("test counter done");
      cpu_mode_pin <= 2'h2;
      repeat (4) @(posedge aclk);
      rd(`DMC_IDX_MODE_HI, 34'h10);
      rd(`DMC_IDX_CNT_HI, 34'h0);
      wr(`DMC_IDX_IEN_LO, 32'hf0, `DMC_RESP_SLVERR);
      rd(`DMC_IDX_IEN_HI, 34'h60);
      $display("test high map done");
      repeat (3) @(posedge aclk);
      complete_run();
   end
endmodule
`default_nettype wire
